// file: design/disk_error_status.sv
// drive error detection, classification and apb status registers
// Operation
// - first register: header, data and timing errors
// - third register holds two seek error bits
// - burst or drop span over 11 uncorrectable
// - sector miss with crc fault sets both
// - sector match with crc fault: crc only
// - format fault with crc fault sets both
// - format fault, crc good: format only
// - read ecc mismatch sets data check
// - uncorrectable data sets data check, ecc hard
// - seek over 85 ms sets seek incomplete
// - recalibrate over 500 ms sets seek incomplete
// - offset or centerline over 10 ms too
// - drift off cylinder sets both seek bits
// - sector miss, crc good: compare only
//
// Decided for this implementation: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
module disk_error_status #(
  parameter int unsigned MS_CYCLES = err_pkg::MS_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic header_valid,
  input wire logic sector_match,
  input wire logic header_crc_ok,
  input wire logic format_ok,
  input wire logic read_valid,
  input wire logic ecc_mismatch,
  input wire logic [7:0] ecc_burst_len,
  input wire logic ecc_multi_drop,
  input wire logic [7:0] ecc_drop_span,
  input wire logic timing_fault,
  input wire logic pos_start,
  input wire logic [1:0] pos_op,
  input wire logic pos_done,
  input wire logic on_cylinder,
  output logic error_summary,
  output logic pos_busy
);

  // error and control registers
  logic [err_pkg::ERR1_W-1:0] err1_r; // first error register
  logic [err_pkg::ERR2_W-1:0] err2_r; // second error register
  logic [err_pkg::ERR3_W-1:0] err3_r; // third error register
  logic [err_pkg::CTRL_W-1:0] ctrl_r; // control register
  logic [err_pkg::HARD_CNT_W-1:0] hard_cnt_r; // back-to-back hard reads
  err_pkg::pos_state_t pos_st_r; // positioner tracking state
  logic [1:0] op_r; // op in progress
  logic oncyl_meta_r; // on-cylinder pin, first stage
  logic oncyl_sync_r; // on-cylinder pin, synchronised

  // hardware set and software clear terms
  logic [err_pkg::ERR1_W-1:0] set1;
  logic [err_pkg::ERR2_W-1:0] set2;
  logic [err_pkg::ERR3_W-1:0] set3;
  logic [err_pkg::ERR1_W-1:0] clr1;
  logic [err_pkg::ERR2_W-1:0] clr2;
  logic [err_pkg::ERR3_W-1:0] clr3;
  logic wr_done; // write completes this edge
  logic rd_take; // read data captured this edge
  logic uncorrectable; // data error beyond ecc reach
  logic tmo_expired; // positioning timeout pulse
  logic drift; // positioner left cylinder after settling
  logic [9:0] limit_ms; // timeout for the starting op
  logic [31:0] rd_mux; // read data before capture
  logic rd_hit; // address is mapped
  logic [1:0] pos_code; // state as status bits

  // on-cylinder pin crosses in through two flops
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      oncyl_meta_r <= 1'b0;
      oncyl_sync_r <= 1'b0;
    end
    else
    begin
      oncyl_meta_r <= on_cylinder;
      oncyl_sync_r <= oncyl_meta_r;
    end
  end

  // apb phases: one wait state, write lands on the ready edge
  assign rd_take = psel && penable && !pready;
  assign wr_done = psel && penable && pready && pwrite;

  // write-one-to-clear masks for the error registers
  always_comb
  begin
    clr1 = '0;
    clr2 = '0;
    clr3 = '0;
    if (wr_done && paddr == err_pkg::ERR1_OFF)
      clr1 = pwdata[err_pkg::ERR1_W-1:0];
    if (wr_done && paddr == err_pkg::ERR2_OFF)
      clr2 = pwdata[err_pkg::ERR2_W-1:0];
    if (wr_done && paddr == err_pkg::ERR3_OFF)
      clr3 = pwdata[err_pkg::ERR3_W-1:0];
  end

  // ecc reach: long burst or widely spaced drops
  assign uncorrectable = ecc_mismatch
    && ctrl_r[err_pkg::CTRL_ECC_EN_BIT]
    && ((ecc_burst_len > err_pkg::ECC_MAX_SPAN)
        || (ecc_multi_drop
            && ecc_drop_span > err_pkg::ECC_MAX_SPAN));

  // drift only counts once the positioner has settled
  assign drift = pos_st_r == err_pkg::POS_SETTLED && !oncyl_sync_r
    && ctrl_r[err_pkg::CTRL_DRIFT_BIT] && !pos_start;

  // classify header, data and timing faults into the first register
  always_comb
  begin
    set1 = '0;
    if (header_valid)
    begin
      set1[err_pkg::HDR_CMP_BIT] = !sector_match;
      set1[err_pkg::HDR_CRC_BIT] = !header_crc_ok;
      set1[err_pkg::FMT_FLT_BIT] = !format_ok;
    end
    if (read_valid)
    begin
      set1[err_pkg::DATA_CHK_BIT] = ecc_mismatch;
      set1[err_pkg::ECC_HARD_BIT] = uncorrectable;
    end
    set1[err_pkg::DRV_TIM_BIT] = timing_fault;
  end

  // drive condition errors: timeout cause and seek bits
  always_comb
  begin
    set2 = '0;
    set3 = '0;
    if (tmo_expired)
    begin
      set2[err_pkg::TMO_SEEK_BIT] = op_r == err_pkg::OP_SEEK;
      set2[err_pkg::TMO_RECAL_BIT] = op_r == err_pkg::OP_RECAL;
      set2[err_pkg::TMO_OFFSET_BIT] = op_r[1];
      set3[err_pkg::SEEK_INC_BIT] = 1'b1;
    end
    if (drift)
    begin
      set3[err_pkg::SEEK_INC_BIT] = 1'b1;
      set3[err_pkg::OFF_CYL_BIT] = 1'b1;
    end
  end

  // sticky flags: set beats a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      err1_r <= '0;
      err2_r <= '0;
      err3_r <= '0;
    end
    else
    begin
      err1_r <= (err1_r & ~clr1) | set1;
      err2_r <= (err2_r & ~clr2) | set2;
      err3_r <= (err3_r & ~clr3) | set3;
    end
  end

  // control register steers ecc grading and drift watch
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl_r <= err_pkg::CTRL_RESET;
    else if (wr_done && paddr == err_pkg::CTRL_OFF)
      ctrl_r <= pwdata[err_pkg::CTRL_W-1:0];
  end

  // count consecutive uncorrectable reads, good read restarts it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      hard_cnt_r <= '0;
    else if (read_valid && !uncorrectable)
      hard_cnt_r <= '0;
    else if (read_valid && hard_cnt_r != '1)
      hard_cnt_r <= hard_cnt_r + 8'h01;
  end

  // timeout chosen by the kind of positioning op
  always_comb
  begin
    case (pos_op)
      err_pkg::OP_SEEK: limit_ms = err_pkg::SEEK_TMO_MS;
      err_pkg::OP_RECAL: limit_ms = err_pkg::RECAL_TMO_MS;
      default: limit_ms = err_pkg::OFFSET_TMO_MS;
    endcase
  end

  // millisecond timer for the op in flight
  pos_timer #(
    .MS_CYCLES(MS_CYCLES)
  ) u_timer (
    .pclk(pclk),
    .presetn(presetn),
    .start(pos_start),
    .limit_ms(limit_ms),
    .stop(pos_done),
    .expired(tmo_expired)
  );

  // positioner tracking: moving, settled, or idle after a fault
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pos_st_r <= err_pkg::POS_IDLE;
      op_r <= 2'h0;
    end
    else if (pos_start)
    begin
      pos_st_r <= err_pkg::POS_MOVING;
      op_r <= pos_op;
    end
    else
    begin
      case (pos_st_r)
        err_pkg::POS_MOVING:
          if (tmo_expired)
            pos_st_r <= err_pkg::POS_IDLE;
          else if (pos_done)
            pos_st_r <= err_pkg::POS_SETTLED;
        err_pkg::POS_SETTLED:
          if (drift)
            pos_st_r <= err_pkg::POS_IDLE;
        default:
          pos_st_r <= err_pkg::POS_IDLE;
      endcase
    end
  end

  // state as two status bits
  always_comb
  begin
    case (pos_st_r)
      err_pkg::POS_MOVING: pos_code = 2'h1;
      err_pkg::POS_SETTLED: pos_code = 2'h2;
      default: pos_code = 2'h0;
    endcase
  end

  // read decode; unmapped addresses answer zero with an error
  always_comb
  begin
    rd_mux = 32'h0;
    rd_hit = 1'b1;
    case (paddr)
      err_pkg::ERR1_OFF: rd_mux[err_pkg::ERR1_W-1:0] = err1_r;
      err_pkg::ERR2_OFF: rd_mux[err_pkg::ERR2_W-1:0] = err2_r;
      err_pkg::ERR3_OFF: rd_mux[err_pkg::ERR3_W-1:0] = err3_r;
      err_pkg::CTRL_OFF: rd_mux[err_pkg::CTRL_W-1:0] = ctrl_r;
      err_pkg::STAT_OFF:
      begin
        rd_mux[err_pkg::STAT_POS_LSB +: 2] = pos_code;
        rd_mux[err_pkg::STAT_ONCYL_BIT] = oncyl_sync_r;
        rd_mux[err_pkg::STAT_HARD_LSB +: err_pkg::HARD_CNT_W] = hard_cnt_r;
      end
      default: rd_hit = 1'b0;
    endcase
  end

  // apb answer flops
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= rd_take;
      if (rd_take)
      begin
        prdata <= pwrite ? 32'h0 : rd_mux;
        pslverr <= !rd_hit;
      end
      else
        pslverr <= 1'b0;
    end
  end

  // summary and busy outputs
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      error_summary <= 1'b0;
      pos_busy <= 1'b0;
    end
    else
    begin
      error_summary <= |{set1, set2, set3, err1_r & ~clr1,
                         err2_r & ~clr2, err3_r & ~clr3};
      pos_busy <= pos_start
        || (pos_st_r == err_pkg::POS_MOVING && !pos_done && !tmo_expired);
    end
  end

  // helper: cycles since the op started
  logic [31:0] move_cyc_r;
  logic [31:0] lim_cyc_r;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      move_cyc_r <= 32'h0;
      lim_cyc_r <= 32'h0;
    end
    else if (pos_start)
    begin
      move_cyc_r <= 32'h0;
      lim_cyc_r <= 32'(limit_ms) * 32'(MS_CYCLES);
    end
    else
      move_cyc_r <= move_cyc_r + 32'h1;
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence hdr_crc_bad_s;
    header_valid && !header_crc_ok && !clr1[err_pkg::HDR_CRC_BIT];
  endsequence

  a_hdr_both_set: assert property (
    hdr_crc_bad_s and (!sector_match && !clr1[err_pkg::HDR_CMP_BIT])
    |=> err1_r[err_pkg::HDR_CMP_BIT] && err1_r[err_pkg::HDR_CRC_BIT])
    else $error("sector miss with crc fault lost a flag");

  a_hdr_crc_only: assert property (
    hdr_crc_bad_s and (sector_match && !err1_r[err_pkg::HDR_CMP_BIT])
    |=> err1_r[err_pkg::HDR_CRC_BIT] && !err1_r[err_pkg::HDR_CMP_BIT])
    else $error("crc-only header fault set compare flag");

  a_fmt_with_crc: assert property (
    hdr_crc_bad_s and (!format_ok && !clr1[err_pkg::FMT_FLT_BIT])
    |=> err1_r[err_pkg::FMT_FLT_BIT] && err1_r[err_pkg::HDR_CRC_BIT])
    else $error("format fault with crc fault lost a flag");

  a_fmt_no_crc: assert property (
    header_valid && header_crc_ok && !format_ok
    && !err1_r[err_pkg::HDR_CRC_BIT] && !clr1[err_pkg::FMT_FLT_BIT]
    |=> err1_r[err_pkg::FMT_FLT_BIT] && !err1_r[err_pkg::HDR_CRC_BIT])
    else $error("wrong format pack not reported alone");

  a_cmp_only: assert property (
    header_valid && !sector_match && header_crc_ok
    && !err1_r[err_pkg::HDR_CRC_BIT] && !clr1[err_pkg::HDR_CMP_BIT]
    |=> err1_r[err_pkg::HDR_CMP_BIT] && !err1_r[err_pkg::HDR_CRC_BIT])
    else $error("compare-only fault set crc flag");

  a_data_hard: assert property (
    read_valid && ecc_mismatch && ctrl_r[err_pkg::CTRL_ECC_EN_BIT]
    && ecc_burst_len > 8'h0b
    |=> err1_r[err_pkg::DATA_CHK_BIT] && err1_r[err_pkg::ECC_HARD_BIT])
    else $error("long burst not reported as hard");

  a_data_soft: assert property (
    read_valid && ecc_mismatch && ecc_burst_len <= 8'h0b
    && !ecc_multi_drop && !err1_r[err_pkg::ECC_HARD_BIT]
    |=> !err1_r[err_pkg::ECC_HARD_BIT])
    else $error("correctable burst flagged as hard");

  a_tmo_length: assert property (
    tmo_expired |-> move_cyc_r == lim_cyc_r
    ##1 err3_r[err_pkg::SEEK_INC_BIT])
    else $error("positioning timeout at wrong cycle");

  a_drift_seek: assert property (
    pos_st_r == err_pkg::POS_SETTLED
    && $fell(oncyl_sync_r) && ctrl_r[err_pkg::CTRL_DRIFT_BIT]
    && !pos_start
    |=> err3_r[err_pkg::SEEK_INC_BIT] && err3_r[err_pkg::OFF_CYL_BIT])
    else $error("off-cylinder drift not reported");

  a_flag_sticky: assert property (
    err3_r[err_pkg::OFF_CYL_BIT] && !clr3[err_pkg::OFF_CYL_BIT]
    |=> err3_r[err_pkg::OFF_CYL_BIT])
    else $error("error flag dropped without a clear");

endmodule : disk_error_status

// file: design/err_pkg.sv
// shared constants and types for the drive error status logic
package err_pkg;

  // clock rate and the millisecond base for positioning timeouts
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned MS_PER_S = 1000;
  localparam int unsigned MS_CYCLES = CLK_HZ / MS_PER_S;

  // positioning timeouts in milliseconds
  localparam logic [9:0] SEEK_TMO_MS = 10'h055;
  localparam logic [9:0] RECAL_TMO_MS = 10'h1f4;
  localparam logic [9:0] OFFSET_TMO_MS = 10'h00a;

  // longest burst and widest drop spacing that ecc still corrects
  localparam logic [7:0] ECC_MAX_SPAN = 8'h0b;

  // register byte offsets on the apb bus
  localparam logic [7:0] ERR1_OFF = 8'h00;
  localparam logic [7:0] ERR2_OFF = 8'h04;
  localparam logic [7:0] ERR3_OFF = 8'h08;
  localparam logic [7:0] CTRL_OFF = 8'h0c;
  localparam logic [7:0] STAT_OFF = 8'h10;

  // first error register fields
  localparam int HDR_CMP_BIT = 0;
  localparam int HDR_CRC_BIT = 1;
  localparam int FMT_FLT_BIT = 2;
  localparam int DATA_CHK_BIT = 3;
  localparam int ECC_HARD_BIT = 4;
  localparam int DRV_TIM_BIT = 5;
  localparam int ERR1_W = 6;

  // second error register: which positioning op timed out
  localparam int TMO_SEEK_BIT = 0;
  localparam int TMO_RECAL_BIT = 1;
  localparam int TMO_OFFSET_BIT = 2;
  localparam int ERR2_W = 3;

  // third error register: seek error bits
  localparam int SEEK_INC_BIT = 0;
  localparam int OFF_CYL_BIT = 1;
  localparam int ERR3_W = 2;

  // control register fields and reset value
  localparam int CTRL_ECC_EN_BIT = 0;
  localparam int CTRL_DRIFT_BIT = 1;
  localparam int CTRL_W = 2;
  localparam logic [1:0] CTRL_RESET = 2'h3;

  // status register fields
  localparam int STAT_POS_LSB = 0;
  localparam int STAT_ONCYL_BIT = 2;
  localparam int STAT_HARD_LSB = 8;
  localparam int HARD_CNT_W = 8;

  // positioning operation codes from the drive control logic
  typedef enum logic [1:0] {OP_SEEK, OP_RECAL, OP_OFFSET, OP_RTC} pos_op_t;

  // positioner tracking states
  typedef enum logic [1:0] {POS_IDLE, POS_MOVING, POS_SETTLED} pos_state_t;

endpackage : err_pkg

// file: design/pos_timer.sv
// millisecond timeout timer for positioning operations
`timescale 1ns/1ps
module pos_timer #(
  parameter int unsigned MS_CYCLES = err_pkg::MS_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire logic [9:0] limit_ms,
  input wire logic stop,
  output logic expired
);

  // a zero-length millisecond cannot be counted
  if (MS_CYCLES < 2)
  begin : g_bad_ms
    $error("pos_timer: MS_CYCLES must be at least 2");
  end

  logic busy_r; // timer running
  logic [31:0] ms_cnt_r; // cycles within the current millisecond
  logic [9:0] elapsed_r; // whole milliseconds elapsed
  logic [9:0] limit_r; // captured limit
  logic tick; // last cycle of a millisecond

  assign tick = busy_r && (ms_cnt_r == 32'(MS_CYCLES - 1));

  // run state: start restarts, stop or expiry ends it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      busy_r <= 1'b0;
    else if (start)
      busy_r <= 1'b1;
    else if (stop || expired)
      busy_r <= 1'b0;
  end

  // millisecond divider and elapsed count
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ms_cnt_r <= 32'h0;
      elapsed_r <= 10'h000;
      limit_r <= 10'h000;
    end
    else if (start)
    begin
      ms_cnt_r <= 32'h0;
      elapsed_r <= 10'h000;
      limit_r <= limit_ms;
    end
    else if (tick)
    begin
      ms_cnt_r <= 32'h0;
      elapsed_r <= elapsed_r + 10'h001;
    end
    else if (busy_r)
      ms_cnt_r <= ms_cnt_r + 32'h1;
  end

  // one-cycle expiry pulse when the limit is fully used up
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      expired <= 1'b0;
    else
      expired <= tick && !start && !stop && !expired
                 && (elapsed_r + 10'h001 == limit_r);
  end

endmodule : pos_timer

// file: testbench/ctrl_model.sv
// apb master model standing in for the disk controller
`timescale 1ns/1ps
module ctrl_model (
  input wire logic pclk,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata
);
  // read recovery plan of the controller
  localparam int RETRIES = 28;
  localparam int NOMINAL = 16;
  // head offsets in microinches, low and high density
  localparam int OFS_LO[3] = '{400, 800, 1200};
  localparam int OFS_HI[3] = '{200, 400, 600};

  // bus idle at time zero
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'hff;
    pwdata = 32'h0;
  end

  // one transfer: setup, access until pready, then release
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    // released lines show no stale value
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask : xfer
endmodule : ctrl_model

// file: testbench/tb_top.sv
// self-checking bench for the drive error status logic
`timescale 1ns/1ps
module tb_top;
  localparam int MSC = 10; // shortened millisecond
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr, ecc_burst_len, ecc_drop_span;
  logic [31:0] pwdata, prdata;
  logic header_valid, sector_match, header_crc_ok, format_ok;
  logic read_valid, ecc_mismatch, ecc_multi_drop, timing_fault;
  logic pos_start, pos_done, on_cylinder, error_summary, pos_busy;
  logic [1:0] pos_op;
  logic [32:0] exp_q[$]; // expected {pslverr, prdata}
  logic [32:0] e_m;
  int fails, tests_run;
  int lms[4] = '{85, 500, 10, 10};
  logic [2:0] cause[4] = '{3'h1, 3'h2, 3'h4, 3'h4};
  logic [2:0] hc[5] = '{3'b001, 3'b101, 3'b100, 3'b110, 3'b011};
  logic [5:0] he[5] = '{6'h03, 6'h02, 6'h06, 6'h04, 6'h01};
  logic [7:0] eb[5] = '{8'd11, 8'd12, 8'd3, 8'd3, 8'd0};
  logic [8:0] es[5] = '{9'h000, 9'h000, 9'h10b, 9'h10c, 9'h000};
  logic [5:0] ee[5] = '{6'h08, 6'h18, 6'h08, 6'h18, 6'h08};

  disk_error_status #(.MS_CYCLES(MSC)) u_dut (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .header_valid(header_valid),
    .sector_match(sector_match), .header_crc_ok(header_crc_ok),
    .format_ok(format_ok), .read_valid(read_valid),
    .ecc_mismatch(ecc_mismatch), .ecc_burst_len(ecc_burst_len),
    .ecc_multi_drop(ecc_multi_drop), .ecc_drop_span(ecc_drop_span),
    .timing_fault(timing_fault), .pos_start(pos_start), .pos_op(pos_op),
    .pos_done(pos_done), .on_cylinder(on_cylinder),
    .error_summary(error_summary), .pos_busy(pos_busy));

  ctrl_model u_ctrl (.pclk(pclk), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata));

  // clock, 20 ns period
  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // compare and count
  task check(input string name, input logic [32:0] seen, exp);
    tests_run++;
    if (seen !== exp)
    begin
      fails++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // verdict and end of run
  task wrap_up;
    if (fails == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : wrap_up

  // note the expected read result, then read
  task rd(input logic [7:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    u_ctrl.xfer(1'b0, a, 32'h0);
  endtask : rd

  // register write
  task wr(input logic [7:0] a, input logic [31:0] d);
    u_ctrl.xfer(1'b1, a, d);
  endtask : wr

  // wait some cycles
  task tick(input int n);
    repeat (n) @(posedge pclk);
  endtask : tick

  // header check pulse with levels m, c, f
  task hdr(input logic [2:0] mcf);
    @(posedge pclk);
    {sector_match, header_crc_ok, format_ok} <= mcf;
    header_valid <= 1'b1;
    @(posedge pclk);
    header_valid <= 1'b0;
  endtask : hdr

  // sector read pulse with ecc result
  task rdsec(input logic mis, input logic [7:0] b, input logic [8:0] md);
    @(posedge pclk);
    ecc_mismatch <= mis;
    ecc_burst_len <= b;
    {ecc_multi_drop, ecc_drop_span} <= md;
    read_valid <= 1'b1;
    @(posedge pclk);
    read_valid <= 1'b0;
  endtask : rdsec

  // start a positioning op of kind k
  task pstart(input logic [1:0] k);
    @(posedge pclk);
    pos_op <= k;
    pos_start <= 1'b1;
    @(posedge pclk);
    pos_start <= 1'b0;
  endtask : pstart

  // read result watcher takes the oldest note
  always @(posedge pclk)
  begin
    if (psel && penable && pready === 1'b1 && !pwrite)
    begin
      e_m = (exp_q.size() > 0) ? exp_q.pop_front() : 33'hx;
      check("prdata", {pslverr, prdata}, e_m);
    end
  end

  // watchdog on a hung run
  initial
  begin
    #(20 * 20000);
    fails++;
    wrap_up();
  end

  // main sequence
  initial
  begin
    presetn = 1'b0;
    {header_valid, read_valid, timing_fault, pos_start, pos_done} = 5'h0;
    {sector_match, header_crc_ok, format_ok, on_cylinder} = 4'hf;
    {ecc_mismatch, ecc_multi_drop, pos_op} = 4'h0;
    ecc_burst_len = 8'h0;
    ecc_drop_span = 8'h0;
    fails = 0;
    tests_run = 0;
    void'($urandom(32'hf010));
    tick(8);
    presetn <= 1'b1;
    rd(err_pkg::ERR1_OFF, 33'h0);
    rd(err_pkg::CTRL_OFF, 33'h3);
    rd(8'h14, 33'h1_0000_0000);
    // header fault classes
    for (int i = 0; i < 5; i++)
    begin
      hdr(hc[i]);
      tick(5);
      rd(err_pkg::ERR1_OFF, {27'h0, he[i]});
      rd(err_pkg::ERR1_OFF, {27'h0, he[i]});
      check("error_summary", {32'h0, error_summary}, 33'h1);
      wr(err_pkg::ERR1_OFF, 32'h3f);
      rd(err_pkg::ERR1_OFF, 33'h0);
      check("error_summary", {32'h0, error_summary}, 33'h0);
    end
    // ecc grading at the span boundary
    eb[4] = 8'($urandom_range(11, 0));
    for (int i = 0; i < 5; i++)
    begin
      rdsec(1'b1, eb[i], es[i]);
      rd(err_pkg::ERR1_OFF, {27'h0, ee[i]});
      wr(err_pkg::ERR1_OFF, 32'h3f);
    end
    wr(err_pkg::CTRL_OFF, 32'h2);
    rdsec(1'b1, 8'd40, 9'h0);
    rd(err_pkg::ERR1_OFF, 33'h08);
    wr(err_pkg::CTRL_OFF, 32'h3);
    // full retry sequence stays uncorrectable
    for (int i = 0; i < u_ctrl.RETRIES; i++)
      rdsec(1'b1, 8'd20, 9'h0);
    rd(err_pkg::STAT_OFF, 33'h1c04);
    rd(err_pkg::ERR1_OFF, 33'h18);
    wr(err_pkg::ERR1_OFF, 32'h3f);
    rdsec(1'b0, 8'd0, 9'h0);
    rd(err_pkg::STAT_OFF, 33'h0004);
    rd(err_pkg::ERR1_OFF, 33'h0);
    @(posedge pclk);
    timing_fault <= 1'b1;
    @(posedge pclk);
    timing_fault <= 1'b0;
    rd(err_pkg::ERR1_OFF, 33'h20);
    wr(err_pkg::ERR1_OFF, 32'h3f);
    // positioning timeouts for each op kind
    for (int i = 0; i < 4; i++)
    begin
      pstart(2'(i));
      tick(lms[i] * MSC - 12);
      rd(err_pkg::ERR3_OFF, 33'h0);
      check("pos_busy", {32'h0, pos_busy}, 33'h1);
      tick(15);
      rd(err_pkg::ERR3_OFF, 33'h1);
      rd(err_pkg::ERR2_OFF, {30'h0, cause[i]});
      check("pos_busy", {32'h0, pos_busy}, 33'h0);
      wr(err_pkg::ERR3_OFF, 32'h3);
      wr(err_pkg::ERR2_OFF, 32'h7);
    end
    // completed seek, then drift off cylinder
    pstart(2'h0);
    tick(50);
    pos_done <= 1'b1;
    @(posedge pclk);
    pos_done <= 1'b0;
    tick(3);
    rd(err_pkg::STAT_OFF, 33'h0006);
    rd(err_pkg::ERR3_OFF, 33'h0);
    on_cylinder <= 1'b0;
    tick(6);
    rd(err_pkg::ERR3_OFF, 33'h3);
    rd(err_pkg::STAT_OFF, 33'h0);
    tick(4);
    wrap_up();
  end
endmodule : tb_top
